// file: design/raster_pixel_format_control.sv
`timescale 1ns/10ps
`default_nettype none

module raster_pixel_format_control #(
   parameter int ADDR_W = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire raster_pixel_pkg::fbWord_t fbWord,
   input wire logic fbValid,
   output logic fbReady,
   input wire logic pixelTick,
   output logic dmaRequest,
   output logic [15:0] panelPixelLines,
   output logic panelIsPalette,
   output logic panelValid,
   input wire logic panelReady,
   output logic halfByteMode,
   output logic scanEnable
);

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] statusWord;

   logic enable;
   logic unpack;
   logic wideMap;
   logic activePanel;
   raster_pixel_pkg::load_t loadSel;
   logic [raster_pixel_pkg::HOLD_W-1:0] holdSetting;

   assign enable = ctrl_q[raster_pixel_pkg::ENABLE_BIT];
   assign unpack = ctrl_q[raster_pixel_pkg::UNPACK_BIT];
   assign wideMap = ctrl_q[raster_pixel_pkg::WIDE_MAP_BIT];
   assign activePanel = ctrl_q[raster_pixel_pkg::PANEL_BIT];
   assign loadSel = raster_pixel_pkg::load_t'(ctrl_q[raster_pixel_pkg::LOAD_SEL_LSB +: 2]);
   assign holdSetting = ctrl_q[raster_pixel_pkg::HOLD_LSB +: raster_pixel_pkg::HOLD_W];

   // ------------------------------------------------------------
   // buffer and hold-off state
   // ------------------------------------------------------------
   raster_pixel_pkg::panelWord_t head_q, head_d;
   raster_pixel_pkg::panelWord_t spare_q, spare_d;
   logic headValid_q, headValid_d;
   logic spareValid_q, spareValid_d;
   logic ready_q, ready_d;
   logic [raster_pixel_pkg::LOAD_CNT_W-1:0] loaded_q, loaded_d;
   logic [raster_pixel_pkg::HOLD_W-1:0] hold_q, hold_d;
   logic dmaReq_q, dmaReq_d;

   raster_pixel_pkg::panelWord_t fmt;
   logic [11:0] rgb;
   logic keep;
   logic push;
   logic store;
   logic pop;

   assign statusWord = {14'h0000, spareValid_q, headValid_q, hold_q, 3'h0, loaded_q};

   always_comb begin
      ctrl_d = ctrl_q;
      rdata_d = 32'h00000000;
      if (regWrite && regAddr == ADDR_W'(raster_pixel_pkg::CTRL_ADDR)) begin
         ctrl_d = regWdata & raster_pixel_pkg::CTRL_RW_MASK;
      end
      // read data stands for one cycle only, unmapped reads give zero
      if (regRead) begin
         unique case (regAddr)
            ADDR_W'(raster_pixel_pkg::CTRL_ADDR): begin
               rdata_d = ctrl_q;
            end
            ADDR_W'(raster_pixel_pkg::STATUS_ADDR): begin
               rdata_d = statusWord;
            end
            default: begin
               rdata_d = 32'h00000000;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // register file state
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= raster_pixel_pkg::CTRL_RESET;
         rdata_q <= 32'h00000000;
      end else begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   // ------------------------------------------------------------
   // pixel formatting
   // ------------------------------------------------------------
   always_comb begin
      rgb = fbWord.data[11:0];
      fmt.isPalette = fbWord.isPalette;
      fmt.lines = fbWord.data;
      if (!fbWord.isPalette) begin
         if (!activePanel) begin
            if (unpack && fbWord.depth == raster_pixel_pkg::DEPTH_12) begin
               rgb = {fbWord.data[15:12], fbWord.data[10:7], fbWord.data[4:1]};
            end else begin
               rgb = fbWord.data[11:0];
            end
            fmt.lines = {4'h0, rgb};
         end else begin
            unique case (fbWord.depth)
               raster_pixel_pkg::DEPTH_16: begin
                  // sixteen bit words already carry 5-6-5
                  fmt.lines = fbWord.data;
               end
               raster_pixel_pkg::DEPTH_12: begin
                  fmt.lines = {4'h0, fbWord.data[11:0]};
               end
               raster_pixel_pkg::DEPTH_1,
               raster_pixel_pkg::DEPTH_2,
               raster_pixel_pkg::DEPTH_4,
               raster_pixel_pkg::DEPTH_8: begin
                  if (wideMap) begin
                     fmt.lines = {fbWord.data[11:8], fbWord.data[11], fbWord.data[7:4],
                                  fbWord.data[7:6], fbWord.data[3:0], fbWord.data[3]};
                  end else begin
                     fmt.lines = {4'h0, fbWord.data[11:0]};
                  end
               end
               // depth codes six and seven name no mode
               default: begin
                  fmt.lines = {4'h0, fbWord.data[11:0]};
               end
            endcase
         end
      end
   end

   always_comb begin
      unique case (loadSel)
         raster_pixel_pkg::LOAD_PALETTE: keep = fbWord.isPalette;
         raster_pixel_pkg::LOAD_DATA: keep = !fbWord.isPalette;
         // reserved code behaves like palette and data
         default: keep = 1'b1;
      endcase
   end

   assign push = fbValid && ready_q;
   assign store = push && keep;
   assign pop = headValid_q && panelReady;

   // ------------------------------------------------------------
   // two-entry output buffer
   // ------------------------------------------------------------
   always_comb begin
      head_d = head_q;
      spare_d = spare_q;
      headValid_d = headValid_q && !pop;
      spareValid_d = spareValid_q;
      if (!headValid_d && spareValid_d) begin
         head_d = spare_q;
         headValid_d = 1'b1;
         spareValid_d = 1'b0;
      end
      if (store) begin
         if (headValid_d) begin
            spare_d = fmt;
            spareValid_d = 1'b1;
         end else begin
            head_d = fmt;
            headValid_d = 1'b1;
         end
      end
      if (!enable) begin
         head_d = '0;
         spare_d = '0;
         headValid_d = 1'b0;
         spareValid_d = 1'b0;
      end
      // registered ready: room must exist for a word next cycle
      ready_d = ctrl_d[raster_pixel_pkg::ENABLE_BIT] && enable && !spareValid_d;
   end

   // ------------------------------------------------------------
   // output buffer state
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         head_q <= '0;
         spare_q <= '0;
         headValid_q <= 1'b0;
         spareValid_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         head_q <= head_d;
         spare_q <= spare_d;
         headValid_q <= headValid_d;
         spareValid_q <= spareValid_d;
         ready_q <= ready_d;
      end
   end

   // ------------------------------------------------------------
   // dma request hold-off
   // ------------------------------------------------------------
   always_comb begin
      loaded_d = loaded_q;
      hold_d = hold_q;
      if (hold_q != '0 && pixelTick) begin
         hold_d = hold_q - 1'b1;
      end
      if (push) begin
         if (loaded_q == raster_pixel_pkg::LOAD_BURST - 1'b1) begin
            loaded_d = '0;
            hold_d = holdSetting;
         end else begin
            loaded_d = loaded_q + 1'b1;
         end
      end
      if (!enable) begin
         loaded_d = '0;
         hold_d = '0;
      end
      dmaReq_d = enable && hold_d == '0;
   end

   // ------------------------------------------------------------
   // hold-off state
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loaded_q <= '0;
         hold_q <= '0;
         dmaReq_q <= 1'b0;
      end else begin
         loaded_q <= loaded_d;
         hold_q <= hold_d;
         dmaReq_q <= dmaReq_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign regRdata = rdata_q;
   assign fbReady = ready_q;
   assign dmaRequest = dmaReq_q;
   assign panelPixelLines = head_q.lines;
   assign panelIsPalette = head_q.isPalette;
   assign panelValid = headValid_q;
   assign halfByteMode = ctrl_q[raster_pixel_pkg::HALF_BYTE_BIT];
   assign scanEnable = enable;

endmodule // raster_pixel_format_control

`default_nettype wire

// file: design/raster_pixel_pkg.sv
package raster_pixel_pkg;

   // ------------------------------------------------------------
   // register map and field layout
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam int UNPACK_BIT = 24;
   localparam int WIDE_MAP_BIT = 23;
   localparam int HALF_BYTE_BIT = 22;
   localparam int LOAD_SEL_LSB = 20;
   localparam int HOLD_LSB = 12;
   localparam int HOLD_W = 8;
   localparam int PANEL_BIT = 7;
   localparam int ENABLE_BIT = 0;
   // reserved bits 31:25 and 11:10 read as zero
   localparam logic [31:0] CTRL_RW_MASK = 32'h01fff3ff;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;

   // ------------------------------------------------------------
   // input fifo hold-off
   // ------------------------------------------------------------
   localparam int LOAD_CNT_W = 5;
   localparam logic [LOAD_CNT_W-1:0] LOAD_BURST = 5'h10;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LOAD_BOTH,
      LOAD_PALETTE,
      LOAD_DATA,
      LOAD_RESERVED
   } load_t;

   typedef enum logic [2:0] {
      DEPTH_1,
      DEPTH_2,
      DEPTH_4,
      DEPTH_8,
      DEPTH_12,
      DEPTH_16
   } depth_t;

   typedef struct packed {
      logic isPalette;
      depth_t depth;
      logic [15:0] data;
   } fbWord_t;

   typedef struct packed {
      logic isPalette;
      logic [15:0] lines;
   } panelWord_t;

endpackage

// file: verif/raster_pixel_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module raster_pixel_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   input wire logic fbValid,
   input wire logic fbReady,
   input wire logic panelValid,
   input wire logic panelReady,
   input wire logic [15:0] panelPixelLines,
   input wire logic scanEnable
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   AST_RD_ONE: assert property (regRead ##1 !regRead |=> regRdata == 32'h0)
      else $error("read data held");
   AST_UNMAPPED: assert property (regRead && regAddr == 4'h8 |=> regRdata == 32'h0)
      else $error("unmapped read");
   AST_CTRL_ECHO: assert property (regWrite && regAddr == 4'h0 ##1 regRead && regAddr == 4'h0
      |=> regRdata == ($past(regWdata, 2) & raster_pixel_pkg::CTRL_RW_MASK)) else $error("ctrl");
   AST_IDLE_LINES: assert property (!scanEnable && !$past(scanEnable)
      |-> panelPixelLines == 16'h0 && !panelValid) else $error("lines while off");
   AST_READY_EN: assert property (fbReady |-> $past(scanEnable))
      else $error("ready while off");
   AST_VALID_CAUSE: assert property ($rose(panelValid) |-> $past(fbValid && fbReady))
      else $error("word from nowhere");
   AST_HOLD_HEAD: assert property (panelValid && !panelReady && scanEnable && !regWrite
      |=> panelValid && $stable(panelPixelLines)) else $error("head lost");
   AST_FELL_VALID: assert property ($fell(panelValid) && scanEnable |-> $past(panelReady))
      else $error("head dropped");
   cover property (panelValid && !panelReady);
   cover property (fbValid && !fbReady && scanEnable);
   cover property (regRead && regAddr == 4'h8);
endmodule // raster_pixel_chk
bind raster_pixel_format_control raster_pixel_chk chk (.clk(clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
   .regRdata(regRdata), .fbValid(fbValid), .fbReady(fbReady), .panelValid(panelValid),
   .panelReady(panelReady), .panelPixelLines(panelPixelLines), .scanEnable(scanEnable));
`default_nettype wire

// file: verif/panel_model.sv
`timescale 1ns/10ps
`default_nettype none
module panel_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic panelValid,
   input wire logic [15:0] panelPixelLines,
   input wire logic panelIsPalette,
   output logic panelReady,
   output logic [15:0] lastLines,
   output logic lastPalette,
   output int got
);
   // a stalled panel leaves the head standing in the buffer
   assign panelReady = rst_n && !stall;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         got <= 0;
         lastLines <= 16'h0;
         lastPalette <= 1'b0;
      end else if (panelValid && panelReady) begin
         got <= got + 1;
         lastLines <= panelPixelLines;
         lastPalette <= panelIsPalette;
      end
   end
endmodule // panel_model
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 0;
   logic rst_n = 0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWrite = 0;
   logic regRead = 0;
   logic fbValid = 0;
   logic pixelTick = 0;
   logic stall = 0;
   logic [1:0] tick = 2'h0;
   raster_pixel_pkg::fbWord_t fbWord = '0;
   logic [31:0] regRdata;
   logic fbReady, dmaRequest, panelValid, panelReady;
   logic [15:0] panelPixelLines, lastLines;
   logic panelIsPalette, lastPalette, halfByteMode, scanEnable;
   int got, failures = 0, checked = 0;
   logic [31:0] tc[8] = '{32'h01000000, 32'h0, 32'h01000000, 32'h00c00080,
      32'h00800080, 32'h00400080, 32'h00800080, 32'h01000080};
   logic [19:0] tw[8] = '{20'h4abcd, 20'h4abcd, 20'h3abcd, 20'h0abcd,
      20'h3abcd, 20'h2abcd, 20'h5abcd, 20'h4abcd};
   logic [15:0] te[8] = '{16'h0a76, 16'h0bcd, 16'h0bcd, 16'hbe7b,
      16'hbe7b, 16'h0bcd, 16'habcd, 16'h0bcd};
   always #50 clk = !clk;
   always @(posedge clk) begin
      tick <= tick + 2'h1;
      pixelTick <= tick == 2'h3;
   end
   raster_pixel_format_control DUT (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .fbWord(fbWord), .fbValid(fbValid), .fbReady(fbReady), .pixelTick(pixelTick),
      .dmaRequest(dmaRequest), .panelPixelLines(panelPixelLines),
      .panelIsPalette(panelIsPalette), .panelValid(panelValid), .panelReady(panelReady),
      .halfByteMode(halfByteMode), .scanEnable(scanEnable));
   panel_model panel (.clk(clk), .rst_n(rst_n), .stall(stall), .panelValid(panelValid),
      .panelPixelLines(panelPixelLines), .panelIsPalette(panelIsPalette),
      .panelReady(panelReady), .lastLines(lastLines), .lastPalette(lastPalette),
      .got(got));
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1;
      @(posedge clk);
      regWrite <= 0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      regAddr <= a;
      regRead <= 1;
      @(posedge clk);
      regRead <= 0;
      #1 cmp("regRdata", e, regRdata);
      @(posedge clk);
   endtask
   task cfg(input logic [31:0] c);
      wr(4'h0, 32'h0);
      @(posedge clk);
      wr(4'h0, c);
      @(posedge clk);
      wr(4'h0, c | 32'h1);
      @(posedge clk);
      cmp("halfByteMode", {31'h0, c[raster_pixel_pkg::HALF_BYTE_BIT]}, {31'h0, halfByteMode});
      cmp("scanEnable", 32'h1, {31'h0, scanEnable});
   endtask
   task push(input logic [19:0] w);
      int n;
      n = 0;
      fbWord <= w;
      fbValid <= 1;
      do @(posedge clk); while (fbReady !== 1'b1 && n++ < 40);
      cmp("fbAccept", 32'h1, {31'h0, fbReady});
      fbValid <= 0;
      @(posedge clk);
   endtask
   task xfer(input logic [31:0] c, input logic [19:0] w1, w2, input int k,
      input logic [15:0] e);
      int n0;
      cfg(c);
      n0 = got;
      push(w1);
      push(w2);
      repeat (3) @(posedge clk);
      cmp("count", n0 + k, got);
      cmp("lines", {16'h0, e}, {16'h0, lastLines});
   endtask
   task t_regs;
      rd(4'h0, 32'h0);
      rd(4'h8, 32'h0);
      wr(4'h0, 32'hfffffffe);
      rd(4'h0, 32'h01fff3fe);
      wr(4'h8, 32'hffffffff);
      rd(4'h0, 32'h01fff3fe);
   endtask
   task t_format;
      for (int i = 0; i < 8; i++) xfer(tc[i], tw[i], tw[i], 2, te[i]);
   endtask
   task t_load;
      xfer(32'h00100000, 20'h0abcd, 20'h81234, 1, 16'h1234);
      cmp("isPalette", 32'h1, {31'h0, lastPalette});
      xfer(32'h00200000, 20'h81234, 20'h4abcd, 1, 16'h0bcd);
      cmp("isPalette", 32'h0, {31'h0, lastPalette});
      xfer(32'h0, 20'h81234, 20'h4abcd, 2, 16'h0bcd);
   endtask
   task t_stall;
      int n0;
      cfg(32'h0);
      n0 = got;
      stall <= 1;
      push(20'h4abc1);
      push(20'h4abc2);
      cmp("fbReady", 32'h0, {31'h0, fbReady});
      rd(4'h4, 32'h00030002);
      stall <= 0;
      repeat (4) @(posedge clk);
      cmp("count", n0 + 2, got);
      cmp("lines", 32'h0bc2, {16'h0, lastLines});
   endtask
   task t_hold;
      int ticks;
      ticks = 0;
      cfg(32'h00003000);
      // request rises one cycle after the enabling write lands
      @(posedge clk);
      cmp("dmaRequest", 32'h1, {31'h0, dmaRequest});
      repeat (16) push(20'h40001);
      while (dmaRequest === 1'b0 && ticks < 99) begin
         ticks += pixelTick;
         @(posedge clk);
      end
      cmp("holdTicks", 32'h3, ticks);
   endtask
   task conclude;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      t_regs;
      t_format;
      t_load;
      t_stall;
      t_hold;
      conclude;
   end
   // about two hundred and thirty cycles of work, so this margin only trips on a hang
   initial begin
      #500000;
      failures++;
      conclude;
   end
endmodule // testbench
`default_nettype wire
